// [verilog/cmc_mode_ctrl.sv]
/*
 * operating-mode control of a can 2.0b controller: freeze, disable,
 * loop-back and listen-only, pin parking, resync, plus the receive mask
 * match, which updates on every rx_frame_done, and the transmit buffer pick that the modes gate.
 * assumes the protocol engine supplies bus-state strobes and a bit tick
 * on the same clock, and that control bits arrive as plain ports.
 */
`timescale 1ns/100ps
`include "cmc_defs.svh"

module cmc_mode_ctrl #(
   parameter int NUM_MB = `CMC_NUM_MB,
   parameter int ID_W   = `CMC_ID_W
) (
   input  wire logic                     clock,
   input  wire logic                     nrst,
   // control bits
   input  wire logic                     freeze_enable,
   input  wire logic                     stop_request,
   input  wire logic                     debug_breakpoint_in,
   input  wire logic                     module_disable,
   input  wire logic                     loop_back_enable,
   input  wire logic                     listen_only,
   input  wire logic                     priority_by_id,
   // protocol engine status
   input  wire logic                     bit_tick,
   input  wire logic                     bus_intermission,
   input  wire logic                     bus_idle,
   input  wire logic                     error_passive,
   input  wire logic                     bus_off,
   input  wire logic                     third_intermission_bit,
   input  wire logic                     engine_busy,
   input  wire logic                     engine_tx_bit,
   input  wire logic                     tx_frame_done,
   input  wire logic                     rx_frame_done,
   input  wire logic                     ack_seen_other,
   input  wire logic                     rx_remote,
   input  wire logic [3:0]               rx_dlc,
   input  wire logic [ID_W-1:0]          rx_id,
   input  wire logic [ID_W-1:0]          global_mask,
   input  wire logic [ID_W-1:0]          mb14_mask,
   input  wire logic [ID_W-1:0]          mb15_mask,
   input  wire logic [NUM_MB*ID_W-1:0]   mb_id,
   input  wire logic [NUM_MB-1:0]        mb_rx_en,
   input  wire logic [NUM_MB-1:0]        mb_tx_req,
   // pins
   input  wire logic                     bus_rx_pin,
   output logic                          bus_tx_pin,
   // engine controls
   output logic                          engine_rx_bit,
   output logic                          frames_enable,
   output logic                          prescaler_enable,
   output logic                          module_clock_enable,
   output logic                          ack_slot_ignore,
   output logic                          err_counters_hold,
   output logic                          force_error_passive,
   // status and access control
   output logic                          not_synced_flag,
   output logic                          freeze_acknowledge,
   output logic                          low_power_acknowledge,
   output logic                          err_cnt_write_allow,
   output logic                          all_regs_access,
   output logic                          core_regs_access,
   // frame results
   output logic                          tx_irq_req,
   output logic                          rx_irq_req,
   output logic                          rx_accept,
   output logic                          dominant_bit_error,
   output logic [3:0]                    rx_data_bytes,
   output logic [NUM_MB-1:0]             rx_match,
   output logic [$clog2(NUM_MB)-1:0]     tx_sel_idx,
   output logic                          tx_sel_valid
);

   localparam int IW = $clog2(NUM_MB);

   typedef struct packed {
      cmc_pkg::cmc_state_e st;
      logic                rx_s1;
      logic                rx_s2;
      logic                rx_s3;
      logic                rx_filt;
      logic [3:0]          rec_cnt;
      logic                not_synced;
      logic                frz_ack;
      logic                lp_ack;
      logic                tx_pin;
      logic                rx_bit;
      logic                tx_irq;
      logic                rx_irq;
      logic                accept;
      logic                dom_err;
      logic [3:0]          len;
      logic [NUM_MB-1:0]   match;
      logic [IW-1:0]       sel_idx;
      logic                sel_valid;
   } cmc_regs_s;

   cmc_regs_s s_reg;
   cmc_regs_s s_next;

   logic frz_req;
   logic pins_live;
   logic frames_on;

   // per-buffer mask match and transmit pick chain
   logic [NUM_MB-1:0]   hit;
   logic [NUM_MB:0]     bv;
   logic [ID_W-1:0]     bid  [NUM_MB+1];
   logic [IW-1:0]       bidx [NUM_MB+1];

   assign bv[0]   = 1'b0;
   assign bid[0]  = '0;
   assign bidx[0] = '0;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_MB; gi++) begin : g_mb
         logic [ID_W-1:0] msk;
         logic [ID_W-1:0] my_id;
         logic            better;
         assign my_id = mb_id[gi*ID_W +: ID_W];
         assign msk = (gi == `CMC_MB_OWN_MASK_A) ? mb14_mask :
                      (gi == `CMC_MB_OWN_MASK_B) ? mb15_mask : global_mask;
         assign hit[gi] = mb_rx_en[gi] && (((rx_id ^ my_id) & msk) == '0);
         // strict compare keeps the lower buffer on equal ids
         assign better = mb_tx_req[gi] &&
                         (!bv[gi] || (priority_by_id && (my_id < bid[gi])));
         assign bv[gi+1]   = bv[gi] | mb_tx_req[gi];
         assign bid[gi+1]  = better ? my_id : bid[gi];
         assign bidx[gi+1] = better ? IW'(gi) : bidx[gi];
      end
   endgenerate

   always_comb begin
      s_next = s_reg;
      frz_req = freeze_enable && (stop_request || debug_breakpoint_in);

      // rx pin: three stages, a change counts when the last two agree
      s_next.rx_s1 = bus_rx_pin;
      s_next.rx_s2 = s_reg.rx_s1;
      s_next.rx_s3 = s_reg.rx_s2;
      if (s_reg.rx_s2 == s_reg.rx_s3) begin
         s_next.rx_filt = s_reg.rx_s3;
      end

      case (s_reg.st)
         cmc_pkg::CMC_NORMAL: begin
            if (module_disable) begin
               s_next.st = cmc_pkg::CMC_DIS_BUS;
            end else if (frz_req) begin
               s_next.st = cmc_pkg::CMC_FRZ_BUS;
            end
         end
         cmc_pkg::CMC_FRZ_BUS: begin
            if (!frz_req) begin
               s_next.st = cmc_pkg::CMC_NORMAL;
            end else if (module_disable) begin
               s_next.st = cmc_pkg::CMC_DIS_BUS;
            end else if (bus_intermission || bus_idle || error_passive || bus_off) begin
               s_next.st = cmc_pkg::CMC_FRZ_DRAIN;
            end
         end
         cmc_pkg::CMC_FRZ_DRAIN: begin
            // no way back from here: a half-finished move-in must complete first
            if (!engine_busy) begin
               s_next.st         = cmc_pkg::CMC_FROZEN;
               s_next.not_synced = 1'b1;
               s_next.frz_ack    = 1'b1;
            end
         end
         cmc_pkg::CMC_FROZEN: begin
            if (module_disable) begin
               s_next.st      = cmc_pkg::CMC_DISABLED;
               s_next.lp_ack  = 1'b1;
               s_next.frz_ack = 1'b0;
            end else if (!frz_req) begin
               s_next.st      = cmc_pkg::CMC_RESYNC;
               s_next.frz_ack = 1'b0;
               s_next.rec_cnt = '0;
            end
         end
         cmc_pkg::CMC_RESYNC: begin
            if (module_disable) begin
               s_next.st = cmc_pkg::CMC_DIS_BUS;
            end else if (frz_req) begin
               s_next.st = cmc_pkg::CMC_FRZ_BUS;
            end else if (s_reg.rec_cnt == `CMC_RESYNC_BITS) begin
               s_next.st         = cmc_pkg::CMC_NORMAL;
               s_next.not_synced = 1'b0;
            end else if (bit_tick) begin
               // any dominant bit restarts the run of recessive bits
               s_next.rec_cnt = (s_reg.rx_filt == `CMC_RECESSIVE) ?
                                4'(s_reg.rec_cnt + 4'h1) : 4'h0;
            end
         end
         cmc_pkg::CMC_DIS_BUS: begin
            if (bus_idle || bus_off ||
                (third_intermission_bit && s_reg.rx_filt == `CMC_RECESSIVE)) begin
               s_next.st = cmc_pkg::CMC_DIS_DRAIN;
            end
         end
         cmc_pkg::CMC_DIS_DRAIN: begin
            // a late clear of disable is seen only once the engine is idle
            if (!engine_busy) begin
               s_next.st         = cmc_pkg::CMC_DISABLED;
               s_next.lp_ack     = 1'b1;
               s_next.not_synced = 1'b1;
            end
         end
         cmc_pkg::CMC_DISABLED: begin
            if (!module_disable) begin
               s_next.st      = cmc_pkg::CMC_RESYNC;
               s_next.lp_ack  = 1'b0;
               s_next.frz_ack = 1'b0;
               s_next.rec_cnt = '0;
            end
         end
         default: begin
            s_next.st = cmc_pkg::CMC_RESYNC;
         end
      endcase

      // pins follow the engine through the freeze drain, but only until the disable drain is reached
      pins_live = (s_reg.st == cmc_pkg::CMC_NORMAL) || (s_reg.st == cmc_pkg::CMC_FRZ_BUS) ||
                  (s_reg.st == cmc_pkg::CMC_FRZ_DRAIN) || (s_reg.st == cmc_pkg::CMC_DIS_BUS);
      frames_on = pins_live || (s_reg.st == cmc_pkg::CMC_DIS_DRAIN);

      if (!pins_live || loop_back_enable || listen_only) begin
         s_next.tx_pin = `CMC_RECESSIVE;
      end else begin
         s_next.tx_pin = engine_tx_bit;
      end
      // parking wins over loop-back: a frozen, resyncing or disable-draining engine must see an idle bus
      if (!pins_live) begin
         s_next.rx_bit = `CMC_RECESSIVE;
      end else if (loop_back_enable) begin
         s_next.rx_bit = engine_tx_bit;
      end else begin
         s_next.rx_bit = s_reg.rx_filt;
      end

      // frame interrupts, accept and error only count while frames run; length and match update on every rx_frame_done
      s_next.tx_irq  = frames_on && tx_frame_done && !listen_only;
      s_next.rx_irq  = frames_on && ((rx_frame_done && (!listen_only || ack_seen_other)) ||
                                     (loop_back_enable && tx_frame_done));
      s_next.accept  = frames_on && rx_frame_done && (!listen_only || ack_seen_other);
      s_next.dom_err = frames_on && rx_frame_done && listen_only && !ack_seen_other;
      if (rx_frame_done) begin
         s_next.len = rx_remote ? 4'h0 :
                      (rx_dlc > `CMC_MAX_DATA_BYTES) ? `CMC_MAX_DATA_BYTES : rx_dlc;
         s_next.match = hit;
      end
      // pick is refreshed every cycle; the engine samples it only when it arbitrates
      s_next.sel_idx   = bidx[NUM_MB];
      s_next.sel_valid = bv[NUM_MB] && frames_on && !listen_only;

      // rx stages start recessive so that release cannot fake a dominant edge
      if (!nrst) begin
         s_next            = '0;
         s_next.st         = cmc_pkg::CMC_RESYNC;
         s_next.rx_s1      = `CMC_RECESSIVE;
         s_next.rx_s2      = `CMC_RECESSIVE;
         s_next.rx_s3      = `CMC_RECESSIVE;
         s_next.rx_filt    = `CMC_RECESSIVE;
         s_next.tx_pin     = `CMC_RECESSIVE;
         s_next.rx_bit     = `CMC_RECESSIVE;
         s_next.not_synced = `CMC_RST_NOT_SYNCED;
         s_next.frz_ack    = `CMC_RST_FRZ_ACK;
         s_next.lp_ack     = `CMC_RST_LP_ACK;
      end
   end

   always_ff @(posedge clock) begin
      s_reg <= s_next;
   end

   assign bus_tx_pin            = s_reg.tx_pin;
   assign engine_rx_bit         = s_reg.rx_bit;
   assign frames_enable         = frames_on;
   // prescaler keeps running in resync, which needs bit ticks to count recessive bits
   assign prescaler_enable      = (s_reg.st != cmc_pkg::CMC_FROZEN) &&
                                  (s_reg.st != cmc_pkg::CMC_DISABLED);
   // only the register side keeps its clock while disabled
   assign module_clock_enable   = (s_reg.st != cmc_pkg::CMC_DISABLED);
   assign ack_slot_ignore       = loop_back_enable;
   assign err_counters_hold     = listen_only || !frames_on;
   assign force_error_passive   = listen_only;
   assign not_synced_flag       = s_reg.not_synced;
   assign freeze_acknowledge    = s_reg.frz_ack;
   assign low_power_acknowledge = s_reg.lp_ack;
   assign err_cnt_write_allow   = (s_reg.st == cmc_pkg::CMC_FROZEN);
   assign all_regs_access       = (s_reg.st == cmc_pkg::CMC_FROZEN);
   assign core_regs_access      = (s_reg.st != cmc_pkg::CMC_DISABLED);
   assign tx_irq_req            = s_reg.tx_irq;
   assign rx_irq_req            = s_reg.rx_irq;
   assign rx_accept             = s_reg.accept;
   assign dominant_bit_error    = s_reg.dom_err;
   assign rx_data_bytes         = s_reg.len;
   assign rx_match              = s_reg.match;
   assign tx_sel_idx            = s_reg.sel_idx;
   assign tx_sel_valid          = s_reg.sel_valid;

endmodule

// [pkg/cmc_defs.svh]
/*
 * constants of the can mode control block: counts, levels, reset values.
 * assumes inclusion by bare name from the design file; definitions only.
 */
`ifndef CMC_DEFS_SVH
`define CMC_DEFS_SVH

`define CMC_NUM_MB          16
`define CMC_ID_W            29
`define CMC_RESYNC_BITS     4'hb
`define CMC_MAX_DATA_BYTES  4'h8
`define CMC_RECESSIVE       1'b1
`define CMC_MB_OWN_MASK_A   14
`define CMC_MB_OWN_MASK_B   15
`define CMC_RST_NOT_SYNCED  1'b1
`define CMC_RST_FRZ_ACK     1'b0
`define CMC_RST_LP_ACK      1'b0

`endif

// [pkg/cmc_pkg.sv]
/*
 * types of the can mode control block.
 * assumes nothing beyond a systemverilog compiler.
 */
package cmc_pkg;

   // gray codes along normal -> freeze -> resync and disable-bus -> disabled -> resync paths
   typedef enum logic [2:0] {
      CMC_NORMAL    = 3'h0,
      CMC_FRZ_BUS   = 3'h1,
      CMC_FRZ_DRAIN = 3'h3,
      CMC_FROZEN    = 3'h2,
      CMC_RESYNC    = 3'h6,
      CMC_DIS_BUS   = 3'h7,
      CMC_DIS_DRAIN = 3'h5,
      CMC_DISABLED  = 3'h4
   } cmc_state_e;

endpackage

// [bench/cmc_can_bus.sv]
/*
 * far-side model: transceiver plus remote nodes on a wired-and can bus.
 * assumes the bench raises remote_dom to make a remote node pull dominant.
 */
`timescale 1ns/100ps

module cmc_can_bus (
   input  wire logic bus_tx_pin,
   input  wire logic remote_dom,
   output logic      bus_rx_pin
);
   // the bus idles recessive through its termination, so a released line reads 1
   assign bus_rx_pin = bus_tx_pin & !remote_dom;
endmodule

// [bench/cmc_mode_ctrl_checker.sv]
/*
 * concurrent checks of the can mode control block, bound to its top module.
 * assumes one clock domain and the synchronous active-low reset nrst.
 */
`timescale 1ns/100ps

module cmc_mode_ctrl_checker (
   input wire logic clock,
   input wire logic nrst,
   input wire logic freeze_enable,
   input wire logic module_disable,
   input wire logic loop_back_enable,
   input wire logic listen_only,
   input wire logic tx_frame_done,
   input wire logic rx_frame_done,
   input wire logic ack_seen_other,
   input wire logic bus_tx_pin,
   input wire logic engine_rx_bit,
   input wire logic frames_enable,
   input wire logic prescaler_enable,
   input wire logic module_clock_enable,
   input wire logic err_counters_hold,
   input wire logic force_error_passive,
   input wire logic not_synced_flag,
   input wire logic freeze_acknowledge,
   input wire logic low_power_acknowledge,
   input wire logic err_cnt_write_allow,
   input wire logic all_regs_access,
   input wire logic core_regs_access,
   input wire logic tx_irq_req,
   input wire logic rx_irq_req,
   input wire logic rx_accept,
   input wire logic dominant_bit_error,
   input wire logic tx_sel_valid
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   sequence s_lo_unacked;
      rx_frame_done && frames_enable && listen_only && !ack_seen_other;
   endsequence
   sequence s_loop_tx;
      tx_frame_done && frames_enable && loop_back_enable && !listen_only;
   endsequence

   a_frozen_halt: assert property (freeze_acknowledge |-> !frames_enable && !prescaler_enable)
      else $error("frozen block still runs frames");
   a_frozen_pins: assert property (freeze_acknowledge && $past(freeze_acknowledge)
      |-> bus_tx_pin && engine_rx_bit) else $error("frozen pins not parked");
   a_freeze_flags: assert property ($rose(freeze_acknowledge)
      |-> not_synced_flag && all_regs_access) else $error("freeze entry flags wrong");
   a_err_write_gate: assert property (err_cnt_write_allow == freeze_acknowledge)
      else $error("error counter write outside freeze");
   a_dis_frozen: assert property ($rose(low_power_acknowledge) && $past(freeze_acknowledge)
      |-> !freeze_acknowledge && !module_clock_enable) else $error("disable from freeze wrong");
   a_dis_refuse: assert property (low_power_acknowledge |-> !core_regs_access)
      else $error("core registers open while disabled");
   a_lp_release: assert property (low_power_acknowledge && !module_disable
      |=> !low_power_acknowledge && module_clock_enable) else $error("disable exit late");
   a_loop_pin: assert property (loop_back_enable && $past(loop_back_enable) |-> bus_tx_pin)
      else $error("tx pin driven in loop-back");
   a_loop_irqs: assert property (s_loop_tx |=> tx_irq_req && rx_irq_req)
      else $error("loop-back interrupts missing");
   a_listen_quiet: assert property (listen_only && $past(listen_only)
      |-> bus_tx_pin && !tx_sel_valid && err_counters_hold && force_error_passive)
      else $error("listen-only node active");
   a_listen_ack: assert property (s_lo_unacked |=> dominant_bit_error && !rx_accept)
      else $error("unacknowledged frame accepted");
   a_freeze_exit: assert property (freeze_acknowledge && !freeze_enable
      |=> !freeze_acknowledge) else $error("freeze kept without enable");
endmodule

bind cmc_mode_ctrl cmc_mode_ctrl_checker cmc_mode_ctrl_checker_i (.*);

// [bench/test_can_controller_mode_control.sv]
/*
 * testbench of the can mode control block: resync, freeze, disable,
 * loop-back, listen-only and frame result sequences with expected values.
 * assumes cmc_mode_ctrl, its bound checker and the cmc_can_bus model.
 */
`timescale 1ns/100ps

module test_can_controller_mode_control;
   logic        clock = 1'b0;
   logic        nrst = 1'b0;
   logic        freeze_enable, stop_request, debug_breakpoint_in, module_disable;
   logic        loop_back_enable, listen_only, priority_by_id, bit_tick, bus_intermission;
   logic        bus_idle, error_passive, bus_off, third_intermission_bit, engine_busy;
   logic        engine_tx_bit, tx_frame_done, rx_frame_done, ack_seen_other, rx_remote;
   logic        remote_dom, bus_rx_pin, bus_tx_pin, engine_rx_bit, frames_enable;
   logic        prescaler_enable, module_clock_enable, err_cnt_write_allow, all_regs_access;
   logic        core_regs_access, not_synced_flag, freeze_acknowledge, low_power_acknowledge;
   logic        tx_irq_req, rx_irq_req, rx_accept, dominant_bit_error, tx_sel_valid;
   logic        ack_slot_ignore;
   logic [3:0]  rx_dlc, rx_data_bytes, tx_sel_idx;
   logic [28:0] rx_id, global_mask, mb14_mask, mb15_mask;
   logic [463:0] mb_id;
   logic [15:0] mb_rx_en, mb_tx_req, rx_match;
   int          error_cnt = 0;
   int          checks_done = 0;
   int          k;
   wire [2:0]   st = {not_synced_flag, low_power_acknowledge, freeze_acknowledge};

   cmc_mode_ctrl cmc_mode_ctrl_i (
      .*,
      .ack_slot_ignore     (ack_slot_ignore),
      .err_counters_hold   (),
      .force_error_passive ()
   );
   cmc_can_bus cmc_can_bus_i (.*);

   always #5 clock = ~clock;

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // bounded wait on one status flag: 0 freeze ack, 1 low-power ack, 2 not-synced
   task automatic wt(input int f, input logic v);
      for (int i = 0; i < 60 && st[f] !== v; i++)
         cyc(1);
      chk(st[f], v);
      if (st[f] !== v)
         complete_run();
   endtask

   task automatic tk(input int n);
      repeat (n) begin
         cyc(1);
         bit_tick = 1'b1;
         cyc(1);
         bit_tick = 1'b0;
      end
   endtask

   // exactly eleven recessive bits are needed before the node rejoins
   // the pin may have been dominant just before: let the three-stage filter settle first
   task automatic rs;
      cyc(5);
      tk(10);
      cyc(2);
      chk(not_synced_flag, 1'b1);
      tk(1);
      cyc(1);
      chk(not_synced_flag, 1'b0);
   endtask

   task automatic rxf(input logic a);
      ack_seen_other = a;
      rx_frame_done = 1'b1;
      cyc(1);
      rx_frame_done = 1'b0;
   endtask

   initial begin
      {freeze_enable, stop_request, debug_breakpoint_in, module_disable, loop_back_enable,
       listen_only, priority_by_id, bit_tick, bus_intermission, bus_idle, error_passive,
       bus_off, third_intermission_bit, engine_busy, tx_frame_done, rx_frame_done,
       ack_seen_other, rx_remote, remote_dom} = '0;
      engine_tx_bit = 1'b1;
      rx_dlc = 4'h0;
      rx_id = '0;
      mb_id = '0;
      mb_rx_en = '1;
      mb_tx_req = '0;
      global_mask = '1;
      mb14_mask = '0;
      mb15_mask = '1;
      cyc(4);
      nrst = 1'b1;
      chk(st, 3'h4);
      tk(5);
      remote_dom = 1'b1;
      cyc(5);
      tk(1);
      remote_dom = 1'b0;
      cyc(5);
      rs();
      for (k = 0; k < 4; k++) begin
         {bus_intermission, bus_idle, error_passive, bus_off} = 4'h0;
         engine_busy = 1'b1;
         freeze_enable = 1'b0;
         stop_request = 1'b1;
         debug_breakpoint_in = 1'b1;
         cyc(8);
         chk(st, 3'h0);
         freeze_enable = 1'b1;
         stop_request = !k[0];
         debug_breakpoint_in = k[0];
         cyc(8);
         chk(st, 3'h0);
         {bus_intermission, bus_idle, error_passive, bus_off} = 4'h8 >> k;
         cyc(8);
         chk(st, 3'h0);
         engine_busy = 1'b0;
         engine_tx_bit = 1'b0;
         remote_dom = 1'b1;
         wt(0, 1'b1);
         cyc(2);
         chk({st, prescaler_enable, frames_enable, err_cnt_write_allow, all_regs_access,
              bus_tx_pin, engine_rx_bit}, 9'h14f);
         remote_dom = 1'b0;
         engine_tx_bit = 1'b1;
         if (k == 3) begin
            module_disable = 1'b1;
            wt(1, 1'b1);
            chk({st, module_clock_enable, core_regs_access}, 5'h18);
            debug_breakpoint_in = 1'b0;
            cyc(1);
            module_disable = 1'b0;
            wt(1, 1'b0);
            chk(module_clock_enable, 1'b1);
         end else begin
            freeze_enable = (k != 2);
            stop_request = (k == 2);
            debug_breakpoint_in = 1'b0;
            wt(0, 1'b0);
         end
         rs();
      end
      freeze_enable = 1'b0;
      {bus_intermission, bus_idle, error_passive, bus_off} = 4'h0;
      engine_busy = 1'b1;
      module_disable = 1'b1;
      remote_dom = 1'b1;
      cyc(5);
      third_intermission_bit = 1'b1;
      cyc(1);
      third_intermission_bit = 1'b0;
      remote_dom = 1'b0;
      cyc(8);
      chk(st, 3'h0);
      third_intermission_bit = 1'b1;
      cyc(1);
      third_intermission_bit = 1'b0;
      cyc(8);
      chk(st, 3'h0);
      engine_busy = 1'b0;
      wt(1, 1'b1);
      module_disable = 1'b0;
      wt(1, 1'b0);
      rs();
      loop_back_enable = 1'b1;
      engine_tx_bit = 1'b0;
      cyc(3);
      chk({bus_tx_pin, engine_rx_bit}, 2'h2);
      engine_tx_bit = 1'b1;
      remote_dom = 1'b1;
      cyc(6);
      chk({bus_tx_pin, engine_rx_bit}, 2'h3);
      tx_frame_done = 1'b1;
      cyc(1);
      tx_frame_done = 1'b0;
      chk({tx_irq_req, rx_irq_req, ack_slot_ignore}, 3'h7);
      loop_back_enable = 1'b0;
      remote_dom = 1'b0;
      listen_only = 1'b1;
      engine_tx_bit = 1'b0;
      mb_tx_req = 16'h0006;
      cyc(3);
      chk({bus_tx_pin, tx_sel_valid, ack_slot_ignore}, 3'h4);
      rxf(1'b0);
      chk({dominant_bit_error, rx_accept, rx_irq_req}, 3'h4);
      cyc(1);
      rxf(1'b1);
      chk({dominant_bit_error, rx_accept, rx_irq_req}, 3'h3);
      listen_only = 1'b0;
      engine_tx_bit = 1'b1;
      mb_id[29 +: 29] = 29'h5;
      mb_id[58 +: 29] = 29'h3;
      cyc(2);
      chk({tx_sel_valid, tx_sel_idx}, 5'h11);
      priority_by_id = 1'b1;
      cyc(2);
      chk({tx_sel_valid, tx_sel_idx}, 5'h12);
      rx_id = 29'h1;
      rx_dlc = 4'h9;
      rxf(1'b1);
      chk({rx_match, rx_data_bytes}, 20'h40008);
      rx_remote = 1'b1;
      cyc(1);
      rxf(1'b1);
      chk(rx_data_bytes, 4'h0);
      complete_run();
   end
endmodule
